// *** include/pll_pkg.sv ***
/*
 * Shared constants and types for the loop controller and its supervisor.
 * Assumes one 25 MHz system clock, sys_clk, for both ends.
 */
// Behaviour
// - Gate off blocks detector; oscillator drifts slower.
// - Gated loop keeps clocking without lock.
// - Gate driven by user or switchover flags.
// - Reset clears counters, outputs, lock; nominal oscillator.
// - Reset release restarts and reacquires lock.
// - Supervisor pulses reset on every lock loss.
// - Optional automatic self reset after lock loss.
// - Reset provided for reconfiguration or switchover.
// - Reset released only after reference is stable.
// - Lock only when feedback matches phase, frequency.
// - Supervisor uses both reset and lock.
// - Six feedback modes; LVDS only side-placed.
// - High bandwidth never with external feedback.
// - Side-placed external feedback needs single-ended.
// - Zero-delay mode forbids differential clock pins.
// - External mode: multiply counter drives feedback_out.
// - LVDS mode inverts the capture clock.
// - Normal mode compensates the network delay.
// - Source-synchronous aligns to longest input path.
package pll_pkg;

    // ****************************************************************
    // Feedback modes
    // ****************************************************************
    typedef enum logic [2:0] {
        FB_SRC_SYNC = 3'h0,
        FB_NO_COMP  = 3'h1,
        FB_NORMAL   = 3'h2,
        FB_ZDB      = 3'h3,
        FB_EXT      = 3'h4,
        FB_LVDS     = 3'h5
    } fb_mode_e;

    // ****************************************************************
    // Loop model constants
    // ****************************************************************
    localparam logic [7:0] NOM_HALF    = 8'h04;
    localparam logic [7:0] MAX_HALF    = 8'hFF;
    localparam logic [7:0] DRIFT_LAST  = 8'h3F;
    localparam logic [7:0] LOCK_WIN    = 8'h02;
    localparam logic [2:0] LOCK_COUNT  = 3'h4;
    localparam int         SELF_RST_NS = 400;
    localparam int         MIN_RST_NS  = 1000;
    localparam int         CLK_NS      = 40;
    localparam logic [7:0] SELF_RST_CYC = 8'((SELF_RST_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] MIN_RST_CYC  = 8'((MIN_RST_NS + CLK_NS - 1) / CLK_NS);

    // ****************************************************************
    // Supervisor registers and fields
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam int F_MODE    = 0;
    localparam int F_HI_BW   = 3;
    localparam int F_SIDE    = 4;
    localparam int F_SE      = 5;
    localparam int F_SELF    = 6;
    localparam int F_GSRC    = 7;
    localparam int F_UGATE   = 9;
    localparam int F_RUN     = 10;
    localparam int S_LOCKED  = 0;
    localparam int S_READY   = 1;
    localparam int S_CFG_ERR = 2;
    localparam int S_REJECT  = 3;
    localparam int S_LOSSES  = 8;
    localparam logic [10:0] CTRL_RESET = 11'h000;

    // Gate sources.
    localparam logic [1:0] GSRC_USER = 2'h0;
    localparam logic [1:0] GSRC_ACT  = 2'h1;
    localparam logic [1:0] GSRC_BAD0 = 2'h2;
    localparam logic [1:0] GSRC_BAD1 = 2'h3;

    // Placement and mode legality, shared by both ends.
    function automatic logic cfg_illegal(input logic [2:0] m, input logic hi_bw,
                                         input logic side, input logic se);
        cfg_illegal = (m > 3'h5) ||
                      (m == FB_LVDS && !side) ||
                      (m == FB_EXT && hi_bw) ||
                      (m == FB_EXT && side && !se) ||
                      (m == FB_ZDB && !se);
    endfunction : cfg_illegal

endpackage : pll_pkg

// *** include/pll_link_if.sv ***
/*
 * Control link between the loop controller and its supervisor.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ns
interface pll_link_if;
    import pll_pkg::*;
    logic       pll_reset;
    logic       pfd_enable;
    logic [2:0] mode;
    logic       hi_bw;
    logic       side_lr;
    logic       single_ended;
    logic       self_reset_en;
    logic       locked;
    logic       cfg_err;

    modport dev (input pll_reset, pfd_enable, mode, hi_bw, side_lr, single_ended, self_reset_en,
                 output locked, cfg_err);
    modport sup (output pll_reset, pfd_enable, mode, hi_bw, side_lr, single_ended, self_reset_en,
                 input locked, cfg_err);
endinterface : pll_link_if

// *** logic/pll_loop_core.sv ***
/*
 * Cycle-level model of the loop: phase detector gate, reset, lock
 * detector, oscillator, feedback counter and feedback mode handling.
 * Assumes the reference and feedback pins are asynchronous to sys_clk
 * and much slower than it.
 */
`timescale 1ns/1ns
module pll_loop_core
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Supervisor link
    pll_link_if.dev            link,
    // Pins
    input  wire logic          ref_clk_pin,
    input  wire logic          fb_in_pin,
    // Compensation and division settings
    input  wire logic [2:0]    net_delay,
    input  wire logic [11:0]   path_delay,
    input  wire logic [3:0]    fb_div,
    // Clock outputs and feedback output enable
    output logic               core_clk_q,
    output logic               external_clock_output_q,
    output logic               feedback_out_q,
    output logic               feedback_out_oe_q
);
    import pll_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] ref_s_q, fbi_s_q;
    logic       ref_l_q, ref_p_q, fbi_l_q, fbi_p_q;

    // A level is taken only when the second and third stages agree.
    always_ff @(posedge sys_clk)
    begin
        ref_s_q <= {ref_s_q[1:0], ref_clk_pin};
        fbi_s_q <= {fbi_s_q[1:0], fb_in_pin};
        ref_l_q <= (ref_s_q[1] == ref_s_q[2]) ? ref_s_q[2] : ref_l_q;
        fbi_l_q <= (fbi_s_q[1] == fbi_s_q[2]) ? fbi_s_q[2] : fbi_l_q;
        ref_p_q <= ref_l_q;
        fbi_p_q <= fbi_l_q;
    end

    // ****************************************************************
    // Configuration check and loop reset
    // ****************************************************************
    logic [7:0] self_cnt_q;
    wire  fb_mode_e mode = fb_mode_e'(link.mode);
    wire  cfg_bad  = cfg_illegal(link.mode, link.hi_bw, link.side_lr, link.single_ended);
    wire  loop_rst = !rst_n || link.pll_reset || cfg_bad || (self_cnt_q != 8'h00);
    wire  pfd_en   = link.pfd_enable;

    // ****************************************************************
    // Compensation delay per mode
    // ****************************************************************
    wire [2:0] pd0 = path_delay[2:0];
    wire [2:0] pd1 = path_delay[5:3];
    wire [2:0] pd2 = path_delay[8:6];
    wire [2:0] pd3 = path_delay[11:9];
    wire [2:0] m01 = (pd0 > pd1) ? pd0 : pd1;
    wire [2:0] m23 = (pd2 > pd3) ? pd2 : pd3;
    wire [2:0] pmax = (m01 > m23) ? m01 : m23;
    // Delaying the internal feedback makes the outputs lead by the same amount.
    wire [2:0] comp = (mode == FB_SRC_SYNC) ? pmax :
                      (mode == FB_NORMAL || mode == FB_LVDS) ? net_delay : 3'h0;
    wire       ext_fb = (mode == FB_EXT);

    // ****************************************************************
    // Oscillator and feedback counter
    // ****************************************************************
    logic [7:0] half_q, osc_cnt_q, drift_q;
    logic       osc_q;
    logic [3:0] mcnt_q;
    logic [8:0] fb_hist_q;
    wire  [3:0] m_eff    = (fb_div == 4'h0) ? 4'h1 : fb_div;
    wire        osc_tick = (osc_cnt_q >= half_q - 8'h01);
    wire        osc_rise = osc_tick && !osc_q;
    wire        m_last   = (mcnt_q >= m_eff - 4'h1);
    wire  [3:0] tap      = {1'b0, comp};
    wire  [3:0] tap1     = tap + 4'h1;

    // Feedback event: pin in external mode, compensated internal edge otherwise.
    wire ref_ev = ref_l_q && !ref_p_q;
    wire fb_ev  = ext_fb ? (fbi_l_q && !fbi_p_q)
                         : (fb_hist_q[tap] && !fb_hist_q[tap1]);

    // The oscillator free-runs whatever the detector does.
    always_ff @(posedge sys_clk)
    begin
        if (loop_rst)
        begin
            osc_cnt_q <= 8'h00;
            osc_q     <= 1'b0;
            mcnt_q    <= 4'h0;
            feedback_out_q <= 1'b0;
            fb_hist_q <= 9'h000;
        end
        else
        begin
            osc_cnt_q <= osc_tick ? 8'h00 : osc_cnt_q + 8'h01;
            osc_q     <= osc_tick ? !osc_q : osc_q;
            mcnt_q    <= !osc_rise ? mcnt_q : (m_last ? 4'h0 : mcnt_q + 4'h1);
            feedback_out_q <= (osc_rise && m_last) ? !feedback_out_q : feedback_out_q;
            fb_hist_q <= {fb_hist_q[7:0], feedback_out_q};
        end
    end

    // ****************************************************************
    // Phase detector
    // ****************************************************************
    logic       ref_pend_q, fb_pend_q, locked_q;
    logic [7:0] gap_q;
    logic [2:0] good_q;
    wire both     = ref_ev && fb_ev;
    wire ref_only = ref_ev && !fb_ev;
    wire fb_only  = fb_ev && !ref_ev;
    wire pair_ref = ref_only && fb_pend_q;   // Feedback edge came first.
    wire pair_fb  = fb_only && ref_pend_q;   // Reference edge came first.
    wire near     = (gap_q <= LOCK_WIN);
    wire twice    = (ref_only && ref_pend_q) || (fb_only && fb_pend_q);
    wire hit      = both || ((pair_ref || pair_fb) && near);
    wire miss     = twice || ((pair_ref || pair_fb) && !near);
    wire speed_up = pfd_en && ((ref_only && ref_pend_q) || (pair_fb && !near));
    wire slow_dn  = pfd_en && ((fb_only && fb_pend_q) || (pair_ref && !near));
    wire drift    = !pfd_en && (drift_q == DRIFT_LAST) && (half_q < MAX_HALF);
    wire lol      = locked_q && miss;

    // A single shortened or lengthened half period per detector decision.
    wire [7:0] half_d = (speed_up && half_q > 8'h01) ? half_q - 8'h01 :
                        ((slow_dn || drift) && half_q < MAX_HALF) ? half_q + 8'h01 : half_q;

    always_ff @(posedge sys_clk)
    begin
        if (loop_rst)
        begin
            half_q     <= NOM_HALF;
            drift_q    <= 8'h00;
            ref_pend_q <= 1'b0;
            fb_pend_q  <= 1'b0;
            gap_q      <= 8'h00;
        end
        else
        begin
            half_q     <= half_d;
            drift_q    <= drift_q + 8'h01;
            ref_pend_q <= both ? 1'b0 : ref_ev ? !fb_pend_q : fb_ev ? 1'b0 : ref_pend_q;
            fb_pend_q  <= both ? 1'b0 : fb_ev ? !ref_pend_q : ref_ev ? 1'b0 : fb_pend_q;
            gap_q      <= (ref_ev || fb_ev) ? 8'h00 : (gap_q == 8'hFF ? gap_q : gap_q + 8'h01);
        end
    end

    // ****************************************************************
    // Lock detector and self reset
    // ****************************************************************
    // Lock needs several consecutive aligned edge pairs, so a frequency
    // match with a phase offset beyond LOCK_WIN never reports lock.
    always_ff @(posedge sys_clk)
    begin
        if (loop_rst)
        begin
            good_q   <= 3'h0;
            locked_q <= 1'b0;
        end
        else
        begin
            good_q   <= miss ? 3'h0 : (hit && good_q != LOCK_COUNT) ? good_q + 3'h1 : good_q;
            locked_q <= miss ? 1'b0 : (hit && good_q >= LOCK_COUNT - 3'h1) ? 1'b1 : locked_q;
        end
    end

    // The self reset counter keeps the loop in reset until it counts back down to zero.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            self_cnt_q <= 8'h00;
        else if (lol && link.self_reset_en && !link.pll_reset && !cfg_bad)
            self_cnt_q <= SELF_RST_CYC;
        else if (self_cnt_q != 8'h00)
            self_cnt_q <= self_cnt_q - 8'h01;
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    logic err_q;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            core_clk_q              <= 1'b0;
            external_clock_output_q <= 1'b0;
            feedback_out_oe_q       <= 1'b0;
            err_q                   <= 1'b0;
        end
        else
        begin
            core_clk_q              <= !loop_rst && (osc_q ^ (mode == FB_LVDS));
            external_clock_output_q <= !loop_rst && osc_q;
            feedback_out_oe_q       <= !cfg_bad && (mode == FB_EXT || mode == FB_ZDB);
            err_q                   <= cfg_bad;
        end
    end

    assign link.locked  = locked_q;
    assign link.cfg_err = err_q;

endmodule : pll_loop_core

// *** logic/pll_supervisor.sv ***
/*
 * Supervisor for the loop: register port for software, reset
 * sequencing, lock watch and phase detector gate selection.
 * Assumes switchover flags come from logic on sys_clk.
 */
`timescale 1ns/1ns
module pll_supervisor
(
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // Register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic [31:0]   reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic [31:0]        reg_rdata_q,
    // Reference health and switchover flags
    input  wire logic          ref_stable,
    input  wire logic          active_clk,
    input  wire logic          clk_bad0,
    input  wire logic          clk_bad1,
    // Loop link
    pll_link_if.sup            link,
    // Downstream release
    output logic               ready_q
);
    import pll_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_HOLD = 2'h1,
        ST_WAIT = 2'h2,
        ST_RUN  = 2'h3
    } sup_state_e;

    sup_state_e  state_q;
    logic [10:0] ctrl_q;
    logic [7:0]  hold_q, losses_q;
    logic        reject_q, rst_q, gate_q, locked_p_q;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire       wr_ctrl = reg_wr && (reg_addr == CTRL_OFS);
    wire [2:0] w_mode  = reg_wdata[F_MODE +: 3];
    wire       w_bad   = cfg_illegal(w_mode, reg_wdata[F_HI_BW], reg_wdata[F_SIDE], reg_wdata[F_SE]);
    wire       take    = wr_ctrl && !w_bad;
    wire       lost    = locked_p_q && !link.locked;
    wire [31:0] status = {16'h0000, losses_q, 4'h0, reject_q, link.cfg_err, ready_q, link.locked};
    wire [31:0] rd_sel = (reg_addr == CTRL_OFS)   ? {21'h000000, ctrl_q} :
                         (reg_addr == STATUS_OFS) ? status : 32'h00000000;

    // A refused write leaves the previous configuration in force.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            ctrl_q      <= CTRL_RESET;
            reject_q    <= 1'b0;
            reg_rdata_q <= 32'h00000000;
        end
        else
        begin
            ctrl_q      <= take ? reg_wdata[10:0] : ctrl_q;
            reject_q    <= wr_ctrl ? w_bad : reject_q;
            reg_rdata_q <= reg_rd ? rd_sel : 32'h00000000;
        end
    end

    // ****************************************************************
    // Gate selection
    // ****************************************************************
    wire [1:0] gsrc = ctrl_q[F_GSRC +: 2];
    wire gate_d = (gsrc == GSRC_USER) ? ctrl_q[F_UGATE] :
                  (gsrc == GSRC_ACT)  ? !active_clk :
                  (gsrc == GSRC_BAD0) ? !clk_bad0 : !clk_bad1;

    // ****************************************************************
    // Reset sequencer
    // ****************************************************************
    // Any accepted reconfiguration restarts the loop through reset.
    wire run = ctrl_q[F_RUN];
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_q    <= ST_IDLE;
            hold_q     <= 8'h00;
            rst_q      <= 1'b1;
            ready_q    <= 1'b0;
            losses_q   <= 8'h00;
            gate_q     <= 1'b0;
            locked_p_q <= 1'b0;
        end
        else
        begin
            gate_q     <= gate_d;
            locked_p_q <= link.locked;
            case (state_q)
                ST_IDLE:
                begin
                    rst_q   <= 1'b1;
                    ready_q <= 1'b0;
                    hold_q  <= 8'h00;
                    if (run && ref_stable)
                        state_q <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    rst_q   <= 1'b1;
                    ready_q <= 1'b0;
                    hold_q  <= hold_q + 8'h01;
                    if (!run || !ref_stable)
                        state_q <= ST_IDLE;
                    else if (hold_q >= MIN_RST_CYC - 8'h01)
                    begin
                        rst_q   <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    hold_q <= 8'h00;
                    if (!run || take)
                        state_q <= ST_IDLE;
                    else if (link.locked)
                    begin
                        ready_q <= 1'b1;
                        state_q <= ST_RUN;
                    end
                end
                default:
                begin
                    hold_q <= 8'h00;
                    if (!run || take)
                    begin
                        ready_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    else if (lost)
                    begin
                        ready_q  <= 1'b0;
                        rst_q    <= 1'b1;
                        losses_q <= losses_q + 8'h01;
                        state_q  <= ST_HOLD;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Link drive
    // ****************************************************************
    assign link.pll_reset     = rst_q;
    assign link.pfd_enable    = gate_q;
    assign link.mode          = ctrl_q[F_MODE +: 3];
    assign link.hi_bw         = ctrl_q[F_HI_BW];
    assign link.side_lr       = ctrl_q[F_SIDE];
    assign link.single_ended  = ctrl_q[F_SE];
    assign link.self_reset_en = ctrl_q[F_SELF];

endmodule : pll_supervisor

// *** verif/pll_link_assertions.sv ***
/*
 * Checker for the control link between loop and supervisor.
 * Assumes one clock, sys_clk, and synchronous active-low rst_n.
 */
`timescale 1ns/1ns
module pll_link_assertions
    import pll_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Link signals
    input wire logic       pll_reset,
    input wire logic       pfd_enable,
    input wire logic [2:0] mode,
    input wire logic       hi_bw,
    input wire logic       side_lr,
    input wire logic       single_ended,
    input wire logic       self_reset_en,
    input wire logic       locked,
    input wire logic       cfg_err
);
    import pll_pkg::*;
    logic [7:0] hi_cnt_q;
    logic [7:0] hi_cnt_d;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // Helper logic
    // ****************************************************************
    // Counts how long the loop reset has stood high; saturates so long idles never wrap.
    assign hi_cnt_d = !pll_reset ? 8'h00 : ((hi_cnt_q == 8'hFF) ? hi_cnt_q : hi_cnt_q + 8'h01);
    always_ff @(posedge sys_clk)
    begin
        hi_cnt_q <= rst_n ? hi_cnt_d : 8'h00;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Reset, lock and configuration legality on the link.
    a_reset_drops_lock: assert property (pll_reset |=> !locked)
        else $error("lock stayed up under loop reset");
    a_lock_after_release: assert property ($rose(locked) |-> !pll_reset && !$past(pll_reset, 4))
        else $error("lock rose too soon after loop reset");
    a_loss_reasserts: assert property ($fell(locked) && !pll_reset |-> ##[0:3] pll_reset)
        else $error("loop reset not pulsed after lock loss");
    a_reset_min_hold: assert property ($fell(pll_reset) |-> hi_cnt_q >= MIN_RST_CYC)
        else $error("loop reset released too early");
    a_no_hibw_ext: assert property (!(mode == FB_EXT && hi_bw))
        else $error("high bandwidth with external feedback");
    a_lvds_side_only: assert property (mode == FB_LVDS |-> side_lr)
        else $error("lvds mode on a non-side loop");
    a_ext_side_se: assert property (mode == FB_EXT && side_lr |-> single_ended)
        else $error("side external feedback not single ended");
    a_zdb_single: assert property (mode == FB_ZDB |-> single_ended)
        else $error("zero delay mode with differential pins");

    // Main scenarios reached.
    c_lock: cover property ($rose(locked));
    c_loss: cover property ($fell(locked) ##[1:3] pll_reset);
    c_ext: cover property (mode == FB_EXT && !pll_reset);
endmodule : pll_link_assertions

// *** verif/tb.sv ***
/*
 * Self-checking bench joining loop and supervisor over the link.
 * Assumes a 25 MHz sys_clk and a slow reference made here.
 */
`timescale 1ns/1ns
module tb;
    import pll_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ref_stable = 1'b0;
    logic        clk_bad0 = 1'b0;
    logic        ref_run = 1'b0;
    logic        ref_clk_pin = 1'b0;
    logic        fb_in_pin = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic [31:0] reg_rdata_q;
    logic [2:0]  ref_cnt = 3'h0;
    logic        core_clk_q;
    logic        external_clock_output_q;
    logic        feedback_out_q;
    logic        feedback_out_oe_q;
    logic        ready_q;
    int          failures = 0;
    int          total_checks = 0;

    pll_link_if link();
    pll_loop_core pll_loop_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .link(link), .ref_clk_pin(ref_clk_pin),
        .fb_in_pin(fb_in_pin), .net_delay(3'h1), .path_delay(12'h123), .fb_div(4'h1), .core_clk_q(core_clk_q),
        .external_clock_output_q(external_clock_output_q), .feedback_out_q(feedback_out_q),
        .feedback_out_oe_q(feedback_out_oe_q));
    pll_supervisor pll_supervisor_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .ref_stable(ref_stable), .active_clk(1'b1), .clk_bad0(clk_bad0), .clk_bad1(1'b0), .link(link),
        .ready_q(ready_q));
    pll_link_assertions pll_link_assertions_inst (.sys_clk(sys_clk), .rst_n(rst_n), .pll_reset(link.pll_reset),
        .pfd_enable(link.pfd_enable), .mode(link.mode), .hi_bw(link.hi_bw), .side_lr(link.side_lr),
        .single_ended(link.single_ended), .self_reset_en(link.self_reset_en), .locked(link.locked),
        .cfg_err(link.cfg_err));

    // Clock, and a reference that stands still while stopped; feedback pin loops back the board trace.
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        fb_in_pin <= feedback_out_q;
        if (ref_run)
        begin
            ref_cnt <= ref_cnt + 3'h1;
            ref_clk_pin <= ref_cnt[2];
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask : rd

    // Control word: run, user gate, gate source, self reset off, se, side, hi_bw, mode.
    function automatic logic [31:0] ctl(logic [2:0] m, logic hb, logic sd, logic se, logic [1:0] gs, logic r);
        ctl = {21'h0, r, 1'b1, gs, 1'b0, se, sd, hb, m};
    endfunction : ctl

    // Counts edges of the core clock or the feedback output over a span.
    task toggles(input logic fb, input int cyc, output int n);
        logic p;
        n = 0;
        p = fb ? feedback_out_q : core_clk_q;
        repeat (cyc)
        begin
            @(posedge sys_clk);
            #1 if ((fb ? feedback_out_q : core_clk_q) !== p) n++;
            p = fb ? feedback_out_q : core_clk_q;
        end
    endtask : toggles

    // Reset values and an unmapped read, then every refused pairing leaves the mode untouched.
    task t_regs_refuse();
        logic [31:0] d;
        logic [31:0] bad [5] = '{ctl(FB_EXT, 1, 0, 1, 0, 0), ctl(FB_LVDS, 0, 0, 1, 0, 0),
            ctl(FB_ZDB, 0, 0, 0, 0, 0), ctl(FB_EXT, 0, 1, 0, 0, 0), ctl(3'h6, 0, 1, 1, 0, 0)};
        rd(CTRL_OFS, d);
        check(d, 32'(CTRL_RESET));
        rd(8'h08, d);
        check(d, 32'h00000000);
        foreach (bad[i])
        begin
            wr(CTRL_OFS, bad[i]);
            rd(STATUS_OFS, d);
            check(d[S_REJECT], 1'b1);
            check(link.mode, FB_SRC_SYNC);
        end
    endtask : t_regs_refuse

    // Start with a stable reference, hold reset, lock, then release downstream.
    task t_lock();
        logic [31:0] d;
        ref_run <= 1'b1;
        ref_stable <= 1'b1;
        repeat (40) @(posedge sys_clk);
        wr(CTRL_OFS, ctl(FB_NORMAL, 0, 0, 1, GSRC_BAD0, 1));
        repeat (20) @(posedge sys_clk);
        #1 check(link.pll_reset, 1'b1);
        for (int i = 0; i < 3000 && link.locked !== 1'b1; i++) @(posedge sys_clk);
        check(link.locked, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 check(ready_q, 1'b1);
        rd(STATUS_OFS, d);
        check(d[1:0], 2'h3);
    endtask : t_lock

    // Gate off from a switchover flag: detector blocked, clocks keep running.
    task t_gate();
        int n;
        clk_bad0 <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1 check(link.pfd_enable, 1'b0);
        toggles(1'b0, 40, n);
        check(n > 0, 1'b1);
        clk_bad0 <= 1'b0;
        for (int i = 0; i < 3000 && ready_q !== 1'b1; i++) @(posedge sys_clk);
        check(ready_q, 1'b1);
    endtask : t_gate

    // Reference stops: the loss pulses the loop reset and is counted.
    task t_loss();
        logic [31:0] d;
        ref_run <= 1'b0;
        for (int i = 0; i < 300 && link.pll_reset !== 1'b1; i++) @(posedge sys_clk);
        #1 check(link.pll_reset, 1'b1);
        check(ready_q, 1'b0);
        rd(STATUS_OFS, d);
        check(d[15:8] != 8'h00, 1'b1);
        ref_run <= 1'b1;
    endtask : t_loss

    // External feedback drives the feedback pin from the multiply counter.
    task t_ext();
        int n;
        wr(CTRL_OFS, ctl(FB_EXT, 0, 1, 1, GSRC_USER, 1));
        repeat (4) @(posedge sys_clk);
        #1 check(feedback_out_oe_q, 1'b1);
        toggles(1'b1, 300, n);
        check(n > 0, 1'b1);
    endtask : t_ext

    // Zero-delay drives the feedback pin; LVDS inverts the core clock.
    task t_modes();
        wr(CTRL_OFS, ctl(FB_ZDB, 0, 0, 1, GSRC_USER, 1));
        repeat (4) @(posedge sys_clk);
        #1 check(feedback_out_oe_q, 1'b1);
        wr(CTRL_OFS, ctl(FB_LVDS, 0, 1, 1, GSRC_USER, 1));
        repeat (40) @(posedge sys_clk);
        #1 check(core_clk_q ^ external_clock_output_q, 1'b1);
    endtask : t_modes

    task wrap_up();
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    // Main sequence.
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_regs_refuse();
        t_lock();
        t_gate();
        t_loss();
        t_ext();
        t_modes();
        wrap_up();
    end

    // Watchdog well beyond the expected run of a few thousand cycles.
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        wrap_up();
    end
endmodule : tb
